// [rtl/bup_pkg.sv]
// constants and types shared by the boot upload sequencer
package bup_pkg;
	// system clock
	localparam int unsigned CLK_HZ = 100_000_000;
	// debug serial link, 8 data bits, no parity, 1 stop
	localparam int unsigned BAUD = 115200;
	localparam int unsigned BAUD_DIV = (CLK_HZ + BAUD / 2) / BAUD;
	localparam int unsigned BAUD_W = 10;
	localparam int unsigned UART_BITS = 10;
	localparam logic [3:0] UART_STOP_IDX = 4'h9;
	// xmodem control characters
	localparam logic [7:0] XM_SOH = 8'h01;
	localparam logic [7:0] XM_EOT = 8'h04;
	localparam logic [7:0] XM_ACK = 8'h06;
	localparam logic [7:0] XM_NAK = 8'h15;
	localparam logic [7:0] XM_INVITE = 8'h43;
	localparam logic [7:0] XM_FIRST_BLK = 8'h01;
	// data bytes per block
	localparam int unsigned XM_DATA_LEN = 128;
	localparam int unsigned XM_IDX_W = 7;
	// crc-16 as used by xmodem-crc
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	// memory map
	localparam logic [31:0] SRAM_BASE = 32'h0020_0000;
	localparam logic [31:0] ROM_BASE = 32'h0010_0000;
	localparam logic [11:0] REG_ZERO = 12'h000;
	localparam logic [11:0] REG_ROM = ROM_BASE[31:20];
	localparam logic [11:0] REG_SRAM = SRAM_BASE[31:20];
	// sram size and the part kept for boot working storage
	localparam int unsigned SRAM_BYTES = 16384;
	localparam int unsigned RESERVE_BYTES = 3 * 1024;
	localparam int unsigned IMAGE_LIMIT = SRAM_BYTES - RESERVE_BYTES;
	// boot pins driven for this long when nothing is found
	localparam int unsigned PROBE_TIME_US = 6000;
	localparam int unsigned PROBE_CYC = PROBE_TIME_US * (CLK_HZ / 1_000_000);
	// invite character repeated at this interval
	localparam int unsigned INVITE_TIME_MS = 1000;
	localparam int unsigned INVITE_CYC = INVITE_TIME_MS * (CLK_HZ / 1000);
	// parallel probe and peripheral reset lengths in cycles
	localparam logic [31:0] PAR_CYC = 32'h0000_0010;
	localparam logic [31:0] PERIPH_RST_CYC = 32'h0000_0010;
	// main sequence
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_PROBE_SPI = 4'b0001,
		ST_PROBE_TWI = 4'b0010,
		ST_PROBE_PAR = 4'b0011,
		ST_UPLOAD = 4'b0100,
		ST_PERIPH_RST = 4'b0101,
		ST_IRQ_OFF = 4'b0110,
		ST_FETCH = 4'b0111,
		ST_REMAP = 4'b1000,
		ST_JUMP = 4'b1001,
		ST_RUN = 4'b1010,
		ST_FOUND = 4'b1011
	} bup_state_t;
	// xmodem receiver
	typedef enum logic [3:0] {
		XS_INVITE = 4'b0000,
		XS_WAIT = 4'b0001,
		XS_BLK = 4'b0010,
		XS_NBLK = 4'b0011,
		XS_DATA = 4'b0100,
		XS_CRC1 = 4'b0101,
		XS_CRC2 = 4'b0110,
		XS_REPLY = 4'b0111,
		XS_DONE = 4'b1000
	} bup_xm_t;
	// firmware upgrade phases
	typedef enum logic [1:0] {
		DP_ENUM = 2'b00,
		DP_RECONF = 2'b01,
		DP_XFER = 2'b10,
		DP_MANIF = 2'b11
	} bup_dfu_t;
endpackage : bup_pkg

// [rtl/bup_uart.sv]
// debug serial port, 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ps
module bup_uart (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic rxd,
	output logic txd,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data
);
	localparam int unsigned BAUD_W = bup_pkg::BAUD_W;
	localparam logic [BAUD_W-1:0] DIV_M1 =
		BAUD_W'(bup_pkg::BAUD_DIV - 1);
	localparam logic [BAUD_W-1:0] DIV_HALF =
		BAUD_W'(bup_pkg::BAUD_DIV / 2);
	logic rx_s1_q; // first sync stage
	logic rx_s2_q; // second sync stage
	logic rx_busy_q; // frame in progress
	logic [BAUD_W-1:0] rx_cnt_q; // bit timer
	logic [3:0] rx_bit_q; // bit index, 0 is start
	logic [7:0] rx_sh_q; // data shifter
	logic rx_tick; // one-cycle bit enable
	logic tx_busy_q; // frame in progress
	logic [BAUD_W-1:0] tx_cnt_q; // bit timer
	logic [3:0] tx_left_q; // bits still to send
	logic [9:0] tx_sh_q; // frame shifter
	logic tx_tick; // one-cycle bit enable

	// pin synchroniser
	always_ff @(posedge clk)
	begin
		rx_s1_q <= rxd;
		rx_s2_q <= rx_s1_q;
	end

	assign rx_tick = rx_busy_q && (rx_cnt_q == '0);

	// receive: start edge, then sample at bit centres
	always_ff @(posedge clk)
	begin
		rx_valid <= 1'b0;
		if (!rst_b)
		begin
			rx_busy_q <= 1'b0;
			rx_cnt_q <= '0;
			rx_bit_q <= '0;
			rx_sh_q <= '0;
			rx_data <= '0;
		end
		else if (!rx_busy_q)
		begin
			// idle, wait for falling start bit
			if (!rx_s2_q)
			begin
				rx_busy_q <= 1'b1;
				rx_cnt_q <= DIV_HALF;
				rx_bit_q <= '0;
			end
		end
		else if (rx_tick)
		begin
			rx_cnt_q <= DIV_M1;
			rx_bit_q <= rx_bit_q + 4'h1;
			if (rx_bit_q == '0 && rx_s2_q)
				rx_busy_q <= 1'b0; // glitch, not a start bit
			else if (rx_bit_q == bup_pkg::UART_STOP_IDX)
			begin
				rx_busy_q <= 1'b0;
				// framing error drops the byte
				if (rx_s2_q)
				begin
					rx_valid <= 1'b1; // [R02]
					rx_data <= rx_sh_q;
				end
			end
			else if (rx_bit_q != '0)
				rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]}; // lsb first
		end
		else
			rx_cnt_q <= rx_cnt_q - 1'b1;
	end

	assign tx_tick = tx_busy_q && (tx_cnt_q == '0);
	assign tx_ready = !tx_busy_q;

	// transmit: start, data lsb first, stop shifted out
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			tx_busy_q <= 1'b0;
			tx_cnt_q <= '0;
			tx_left_q <= '0;
			tx_sh_q <= '1;
			txd <= 1'b1;
		end
		else if (!tx_busy_q)
		begin
			txd <= 1'b1;
			if (tx_valid)
			begin
				tx_busy_q <= 1'b1;
				tx_cnt_q <= DIV_M1;
				tx_left_q <= 4'(bup_pkg::UART_BITS - 1);
				tx_sh_q <= {1'b1, tx_data, 1'b0}; // [R02]
				txd <= 1'b0;
			end
		end
		else if (tx_tick)
		begin
			tx_cnt_q <= DIV_M1;
			if (tx_left_q == '0)
			begin
				tx_busy_q <= 1'b0;
				txd <= 1'b1;
			end
			else
			begin
				tx_left_q <= tx_left_q - 4'h1;
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				txd <= tx_sh_q[1];
			end
		end
		else
			tx_cnt_q <= tx_cnt_q - 1'b1;
	end
endmodule : bup_uart

// [rtl/bup_top.sv]
// boot upload sequencer: probe, serial or usb upload, remap and jump
`timescale 1ns/1ps
//
// Overview of operation
// [R01] no boot found: start serial and usb upload
// [R02] serial link 115200 baud, 8N1
// [R03] bytes stored in sram from 0x0020_0000
// [R04] host image below sram size minus 3K
// [R05] after upload: reset peripherals, irqs off, remap
// [R06] after remap sram at zero, rom high
// [R07] jump fetched before remap, executed right after
// [R08] invite transfer by sending C, 0x43
// [R09] block: soh, number, complement, 128 data, crc
// [R10] block number from 01, wraps ff to 00
// [R11] complement byte validates the block number
// [R12] two-byte crc-16 over data checked
// [R13] usb port waits for 48 MHz pll clock
// [R14] usb upgrade: enumerate, reconfigure, transfer, manifest
// [R15] image offset zero lands at sram zero
// [R16] two-wire eeprom answers at address zero
// [R17] parallel probe on chip select zero, 8-bit
// [R18] boot pins driven about 6 ms
// [R19] spi lines outputs; twi clock out, data bidirectional (code only reads twi data, its oe is held low)
// [R20] ack good block, nak bad, end on eot
module bup_top #(
	parameter int unsigned PROBE_CYC = bup_pkg::PROBE_CYC,
	parameter int unsigned INVITE_CYC = bup_pkg::INVITE_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic boot_start,
	input wire logic probe_valid,
	output logic probe_found,
	output logic spi_mosi_o,
	output logic spi_mosi_oe,
	output logic spi_clk_o,
	output logic spi_clk_oe,
	output logic spi_chip_select_zero_o,
	output logic spi_chip_select_zero_oe,
	output logic two_wire_clock_line_o,
	output logic two_wire_clock_line_oe,
	input wire logic two_wire_data_line_i,
	output logic two_wire_data_line_o,
	output logic two_wire_data_line_oe,
	output logic twi_data_level_q,
	output logic external_chip_select_zero_b,
	output logic external_bus_width8,
	input wire logic debug_serial_port_rxd,
	output logic debug_serial_port_txd,
	output logic usb_clock_pll_en,
	input wire logic usb_clock_pll_lock,
	output logic usb_port_en,
	input wire logic usb_enumerated,
	input wire logic usb_upgrade_req,
	input wire logic usb_byte_valid,
	input wire logic [7:0] usb_byte,
	input wire logic usb_manifest,
	output logic [1:0] usb_phase,
	output logic sram_we,
	output logic [31:0] sram_addr,
	output logic [7:0] sram_wdata,
	output logic upload_overflow,
	output logic periph_reset,
	output logic irq_disable,
	output logic jump_fetch,
	output logic remap,
	output logic jump_exec,
	input wire logic [31:0] cpu_addr,
	output logic sel_sram,
	output logic sel_rom
);
	localparam logic [31:0] HALF_M1 = 32'(PROBE_CYC / 2 - 1);
	localparam logic [31:0] INV_M1 = 32'(INVITE_CYC - 1);
	localparam logic [31:0] LIMIT = 32'(bup_pkg::IMAGE_LIMIT);
	localparam int unsigned XM_IDX_W = bup_pkg::XM_IDX_W;
	localparam logic [XM_IDX_W-1:0] IDX_LAST =
		XM_IDX_W'(bup_pkg::XM_DATA_LEN - 1);
	localparam logic [31:0] BLK_BYTES = 32'(bup_pkg::XM_DATA_LEN);

	bup_pkg::bup_state_t st_q; // main sequence
	logic [31:0] tmr_q; // phase timer
	logic up_act; // uploader running
	logic up_done; // either upload complete
	logic sda_s1_q; // twi data sync stages
	logic sda_s2_q;
	logic lk_s1_q; // pll lock sync stages
	logic lk_s2_q;
	bup_pkg::bup_xm_t xs_q; // xmodem receiver
	logic [31:0] itmr_q; // invite repeat timer
	logic [7:0] blk_q; // received block number
	logic [7:0] nblk_q; // received complement
	logic [7:0] exp_q; // expected block number
	logic [7:0] crc_hi_q; // first crc byte
	logic [15:0] crc_q; // running crc
	logic [XM_IDX_W-1:0] idx_q; // data byte index
	logic [31:0] base_q; // image offset of block
	logic [7:0] reply_q; // ack or nak to send
	logic eot_q; // end seen, final ack pending
	logic started_q; // first header seen
	logic hdr_ok; // number and complement agree
	logic new_blk; // block is the expected one
	logic dup_blk; // repeat of the last block
	logic xm_wr; // serial byte to sram
	logic [31:0] xm_off; // its image offset
	logic usb_own_q; // usb path owns the sram
	logic [31:0] usb_cnt_q; // usb image offset
	logic usb_wr; // usb byte to sram
	bup_pkg::bup_dfu_t dp_q; // upgrade phase
	logic tx_valid; // uart handshake
	logic tx_ready;
	logic [7:0] tx_data;
	logic rx_valid;
	logic [7:0] rx_data;

	// crc-16 of one byte, msb first
	function automatic logic [15:0] bup_crc_byte(
		input logic [15:0] c,
		input logic [7:0] d
	);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++)
			r = r[15] ? ((r << 1) ^ bup_pkg::CRC_POLY) : (r << 1);
		return r;
	endfunction : bup_crc_byte

	// pin synchronisers for twi data and usb pll lock
	always_ff @(posedge clk)
	begin
		sda_s1_q <= two_wire_data_line_i;
		sda_s2_q <= sda_s1_q;
		lk_s1_q <= usb_clock_pll_lock;
		lk_s2_q <= lk_s1_q;
	end

	// main boot sequence
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_q <= bup_pkg::ST_IDLE;
			tmr_q <= '0;
		end
		else
		begin
			tmr_q <= tmr_q + 32'h0000_0001;
			case (st_q)
				bup_pkg::ST_IDLE:
				begin
					tmr_q <= '0;
					if (boot_start)
						st_q <= bup_pkg::ST_PROBE_SPI;
				end
				bup_pkg::ST_PROBE_SPI:
				begin
					// spi probe gets half of the drive window
					if (probe_valid)
						st_q <= bup_pkg::ST_FOUND;
					else if (tmr_q == HALF_M1) // [R18]
					begin
						st_q <= bup_pkg::ST_PROBE_TWI;
						tmr_q <= '0;
					end
				end
				bup_pkg::ST_PROBE_TWI:
				begin
					if (probe_valid)
						st_q <= bup_pkg::ST_FOUND;
					else if (tmr_q == HALF_M1) // [R18]
					begin
						st_q <= bup_pkg::ST_PROBE_PAR;
						tmr_q <= '0;
					end
				end
				bup_pkg::ST_PROBE_PAR:
				begin
					if (probe_valid)
						st_q <= bup_pkg::ST_FOUND;
					else if (tmr_q == bup_pkg::PAR_CYC - 32'h0000_0001)
						st_q <= bup_pkg::ST_UPLOAD; // [R01]
				end
				bup_pkg::ST_UPLOAD:
				begin
					tmr_q <= '0;
					if (up_done)
						st_q <= bup_pkg::ST_PERIPH_RST; // [R05]
				end
				bup_pkg::ST_PERIPH_RST:
				begin
					if (tmr_q == bup_pkg::PERIPH_RST_CYC - 32'h0000_0001)
						st_q <= bup_pkg::ST_IRQ_OFF; // [R05]
				end
				bup_pkg::ST_IRQ_OFF: st_q <= bup_pkg::ST_FETCH;
				bup_pkg::ST_FETCH: st_q <= bup_pkg::ST_REMAP; // [R07]
				bup_pkg::ST_REMAP: st_q <= bup_pkg::ST_JUMP; // [R07]
				bup_pkg::ST_JUMP: st_q <= bup_pkg::ST_RUN;
				bup_pkg::ST_RUN: st_q <= bup_pkg::ST_RUN;
				bup_pkg::ST_FOUND: st_q <= bup_pkg::ST_FOUND;
				default: st_q <= bup_pkg::ST_IDLE;
			endcase
		end
	end

	// handover flags that stay set once reached
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			irq_disable <= 1'b0;
			remap <= 1'b0;
		end
		else
		begin
			if (st_q == bup_pkg::ST_IRQ_OFF)
				irq_disable <= 1'b1; // [R05]
			if (st_q == bup_pkg::ST_FETCH)
				remap <= 1'b1; // [R05]
		end
	end

	assign up_act = (st_q == bup_pkg::ST_UPLOAD);
	assign up_done = (xs_q == bup_pkg::XS_DONE) ||
		(dp_q == bup_pkg::DP_MANIF);
	assign probe_found = (st_q == bup_pkg::ST_FOUND);
	assign periph_reset = (st_q == bup_pkg::ST_PERIPH_RST); // [R05]
	assign jump_fetch = (st_q == bup_pkg::ST_FETCH); // [R07]
	assign jump_exec = (st_q == bup_pkg::ST_JUMP); // [R07]

	// probe pins, released outside their own probe
	assign spi_mosi_o = 1'b0;
	assign spi_clk_o = 1'b0;
	assign spi_chip_select_zero_o = 1'b0;
	assign spi_mosi_oe = (st_q == bup_pkg::ST_PROBE_SPI); // [R19]
	assign spi_clk_oe = (st_q == bup_pkg::ST_PROBE_SPI); // [R19]
	assign spi_chip_select_zero_oe =
		(st_q == bup_pkg::ST_PROBE_SPI); // [R19]
	assign two_wire_clock_line_o = 1'b0;
	assign two_wire_clock_line_oe =
		(st_q == bup_pkg::ST_PROBE_TWI); // [R19]
	assign two_wire_data_line_o = 1'b0;
	// open drain: data stays released so the eeprom can answer
	assign two_wire_data_line_oe = 1'b0; // [R19]
	assign external_chip_select_zero_b =
		!(st_q == bup_pkg::ST_PROBE_PAR); // [R17]
	assign external_bus_width8 = (st_q == bup_pkg::ST_PROBE_PAR); // [R17]

	// twi data level seen during the eeprom probe
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			twi_data_level_q <= 1'b1;
		else if (st_q == bup_pkg::ST_PROBE_TWI)
			twi_data_level_q <= sda_s2_q; // [R19]
	end

	// usb pll runs from boot start, port waits for lock
	assign usb_clock_pll_en = (st_q != bup_pkg::ST_IDLE); // [R13]
	assign usb_port_en = up_act && lk_s2_q; // [R13]
	assign usb_phase = dp_q;

	// firmware upgrade phase tracking
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			dp_q <= bup_pkg::DP_ENUM;
		else if (usb_port_en)
		begin
			case (dp_q)
				bup_pkg::DP_ENUM:
					if (usb_enumerated)
						dp_q <= bup_pkg::DP_RECONF; // [R14]
				bup_pkg::DP_RECONF:
					if (usb_upgrade_req)
						dp_q <= bup_pkg::DP_XFER; // [R14]
				bup_pkg::DP_XFER:
					if (usb_manifest && usb_own_q)
						dp_q <= bup_pkg::DP_MANIF; // [R14]
				bup_pkg::DP_MANIF: dp_q <= bup_pkg::DP_MANIF;
				default: dp_q <= bup_pkg::DP_ENUM;
			endcase
		end
	end

	// usb takes the sram only if serial has not started
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			usb_own_q <= 1'b0;
			usb_cnt_q <= '0;
		end
		else
		begin
			if (dp_q == bup_pkg::DP_XFER && !started_q)
				usb_own_q <= 1'b1;
			if (usb_wr)
				usb_cnt_q <= usb_cnt_q + 32'h0000_0001;
		end
	end

	assign usb_wr = usb_port_en && usb_own_q && usb_byte_valid &&
		(dp_q == bup_pkg::DP_XFER) && (usb_cnt_q < LIMIT);

	bup_uart u_uart (
		.clk(clk),
		.rst_b(rst_b),
		.rxd(debug_serial_port_rxd),
		.txd(debug_serial_port_txd),
		.tx_valid(tx_valid),
		.tx_data(tx_data),
		.tx_ready(tx_ready),
		.rx_valid(rx_valid),
		.rx_data(rx_data)
	);

	assign tx_valid = up_act && !usb_own_q &&
		(xs_q == bup_pkg::XS_INVITE || xs_q == bup_pkg::XS_REPLY);
	assign tx_data = (xs_q == bup_pkg::XS_INVITE) ?
		bup_pkg::XM_INVITE : reply_q; // [R08]
	assign hdr_ok = (nblk_q == ~blk_q); // [R11]
	assign new_blk = (blk_q == exp_q);
	assign dup_blk = (blk_q == exp_q - 8'h01);
	assign xm_off = base_q + {{(32 - XM_IDX_W){1'b0}}, idx_q};
	assign xm_wr = (xs_q == bup_pkg::XS_DATA) && rx_valid && hdr_ok &&
		new_blk && !usb_own_q && (xm_off < LIMIT);

	// xmodem-crc receiver
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			xs_q <= bup_pkg::XS_INVITE;
			itmr_q <= '0;
			blk_q <= '0;
			nblk_q <= '0;
			exp_q <= bup_pkg::XM_FIRST_BLK;
			crc_hi_q <= '0;
			crc_q <= bup_pkg::CRC_INIT;
			idx_q <= '0;
			base_q <= '0;
			reply_q <= bup_pkg::XM_NAK;
			eot_q <= 1'b0;
			started_q <= 1'b0;
		end
		else if (up_act && !usb_own_q) // [R01]
		begin
			case (xs_q)
				bup_pkg::XS_INVITE:
				begin
					itmr_q <= '0;
					if (tx_ready)
						xs_q <= bup_pkg::XS_WAIT; // [R08]
				end
				bup_pkg::XS_WAIT:
				begin
					itmr_q <= itmr_q + 32'h0000_0001;
					if (rx_valid && rx_data == bup_pkg::XM_SOH)
					begin
						started_q <= 1'b1;
						xs_q <= bup_pkg::XS_BLK; // [R09]
					end
					else if (rx_valid && rx_data == bup_pkg::XM_EOT &&
						started_q)
					begin
						eot_q <= 1'b1;
						reply_q <= bup_pkg::XM_ACK; // [R20]
						xs_q <= bup_pkg::XS_REPLY;
					end
					else if (!started_q && itmr_q == INV_M1)
						xs_q <= bup_pkg::XS_INVITE; // repeat invite
				end
				bup_pkg::XS_BLK:
					if (rx_valid)
					begin
						blk_q <= rx_data;
						xs_q <= bup_pkg::XS_NBLK;
					end
				bup_pkg::XS_NBLK:
					if (rx_valid)
					begin
						nblk_q <= rx_data;
						crc_q <= bup_pkg::CRC_INIT;
						idx_q <= '0;
						xs_q <= bup_pkg::XS_DATA;
					end
				bup_pkg::XS_DATA:
					if (rx_valid)
					begin
						crc_q <= bup_crc_byte(crc_q, rx_data); // [R12]
						idx_q <= idx_q + 1'b1;
						if (idx_q == IDX_LAST)
							xs_q <= bup_pkg::XS_CRC1; // [R09]
					end
				bup_pkg::XS_CRC1:
					if (rx_valid)
					begin
						crc_hi_q <= rx_data;
						xs_q <= bup_pkg::XS_CRC2;
					end
				bup_pkg::XS_CRC2:
					if (rx_valid)
					begin
						xs_q <= bup_pkg::XS_REPLY;
						reply_q <= bup_pkg::XM_NAK; // [R20]
						if (hdr_ok && crc_q == {crc_hi_q, rx_data}) // [R12]
						begin
							if (new_blk)
							begin
								reply_q <= bup_pkg::XM_ACK; // [R20]
								exp_q <= exp_q + 8'h01; // [R10]
								base_q <= base_q + BLK_BYTES;
							end
							else if (dup_blk)
								reply_q <= bup_pkg::XM_ACK; // [R20]
						end
					end
				bup_pkg::XS_REPLY:
					if (tx_ready)
						xs_q <= eot_q ? bup_pkg::XS_DONE :
							bup_pkg::XS_WAIT; // [R20]
				bup_pkg::XS_DONE: xs_q <= bup_pkg::XS_DONE;
				default: xs_q <= bup_pkg::XS_INVITE;
			endcase
		end
	end

	// single sram write port shared by both upload paths
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sram_we <= 1'b0;
			sram_addr <= bup_pkg::SRAM_BASE;
			sram_wdata <= '0;
			upload_overflow <= 1'b0;
		end
		else
		begin
			sram_we <= xm_wr || usb_wr;
			if (xm_wr)
			begin
				sram_addr <= bup_pkg::SRAM_BASE + xm_off; // [R03] [R15]
				sram_wdata <= rx_data;
			end
			else if (usb_wr)
			begin
				sram_addr <= bup_pkg::SRAM_BASE + usb_cnt_q; // [R03] [R15]
				sram_wdata <= usb_byte;
			end
			// image too large for the free sram
			if ((xs_q == bup_pkg::XS_DATA && rx_valid && new_blk &&
				xm_off >= LIMIT) || (usb_byte_valid && usb_own_q &&
				dp_q == bup_pkg::DP_XFER && usb_cnt_q >= LIMIT))
				upload_overflow <= 1'b1; // [R04]
		end
	end

	// address decode, swapped at zero by the remap
	always_comb
	begin
		sel_sram = 1'b0;
		sel_rom = 1'b0;
		case (cpu_addr[31:20])
			bup_pkg::REG_ZERO:
			begin
				sel_sram = remap; // [R06]
				sel_rom = !remap;
			end
			bup_pkg::REG_ROM: sel_rom = 1'b1; // [R06]
			bup_pkg::REG_SRAM: sel_sram = !remap;
			default:
			begin
				sel_sram = 1'b0;
				sel_rom = 1'b0;
			end
		endcase
	end
endmodule : bup_top

// [sim/bup_checker.sv]
// port-level assertions for the boot upload sequencer
`timescale 1ns/1ps
module bup_checker #(
	parameter int unsigned PROBE_CYC = 200,
	parameter int unsigned INVITE_CYC = 20000
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic probe_found,
	input wire logic spi_mosi_o,
	input wire logic spi_mosi_oe,
	input wire logic spi_clk_o,
	input wire logic spi_clk_oe,
	input wire logic spi_chip_select_zero_o,
	input wire logic spi_chip_select_zero_oe,
	input wire logic two_wire_clock_line_oe,
	input wire logic external_chip_select_zero_b,
	input wire logic external_bus_width8,
	input wire logic usb_clock_pll_en,
	input wire logic usb_port_en,
	input wire logic [1:0] usb_phase,
	input wire logic sram_we,
	input wire logic [31:0] sram_addr,
	input wire logic periph_reset,
	input wire logic irq_disable,
	input wire logic jump_fetch,
	input wire logic remap,
	input wire logic jump_exec,
	input wire logic [31:0] cpu_addr,
	input wire logic sel_sram,
	input wire logic sel_rom
);
	// one clock domain
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// spi lines driven low together, never with the twi clock
	AST_SPI_OUT: assert property (spi_mosi_oe |-> spi_clk_oe &&
		spi_chip_select_zero_oe && !two_wire_clock_line_oe && !spi_mosi_o
		&& !spi_clk_o && !spi_chip_select_zero_o)
		else $error("spi probe lines wrong");
	// spi probe hands over to the twi probe
	AST_SPI_TO_TWI: assert property ($fell(spi_mosi_oe) && !probe_found
		|-> two_wire_clock_line_oe) else $error("twi probe not next");
	// parallel probe uses the 8-bit width
	AST_PAR_W8: assert property (!external_chip_select_zero_b
		|-> external_bus_width8) else $error("par probe width");
	// usb port only after probes and with its clock on
	AST_USB_UP: assert property (usb_port_en |-> usb_clock_pll_en &&
		!spi_mosi_oe && !external_bus_width8) else $error("usb port early");
	// phases step by one
	AST_PHASE: assert property (usb_phase != $past(usb_phase)
		|-> usb_phase == $past(usb_phase) + 2'h1) else $error("phase skip");
	// writes stay in the image window of sram
	AST_SRAM: assert property (sram_we |-> sram_addr >= bup_pkg::SRAM_BASE
		&& sram_addr < bup_pkg::SRAM_BASE + bup_pkg::IMAGE_LIMIT)
		else $error("sram write out of window");
	// peripheral reset lasts 16 cycles
	AST_PRST: assert property ($rose(periph_reset) |-> ##15 periph_reset
		##1 !periph_reset) else $error("periph reset length");
	// interrupts off before the remap
	AST_IRQ: assert property ($fell(periph_reset) |-> !remap
		##[0:2] irq_disable) else $error("irq not disabled");
	// fetch, remap, then jump
	AST_FETCH: assert property (jump_fetch |-> !remap ##1 remap
		##1 jump_exec) else $error("fetch order");
	AST_JUMP: assert property (jump_exec |-> remap && irq_disable
		&& !periph_reset) else $error("jump state");
	// address decode before and after remap
	AST_DEC_PRE: assert property (!remap && cpu_addr[31:20] == 12'h000
		|-> sel_rom && !sel_sram) else $error("decode before remap");
	AST_DEC_POST: assert property (remap && cpu_addr[31:20] == 12'h000
		|-> sel_sram && !sel_rom) else $error("decode after remap");
	// main scenarios reached
	COV_USB: cover property ($rose(usb_port_en));
	COV_WE: cover property (sram_we);
	COV_JUMP: cover property (jump_exec);
endmodule : bup_checker
bind bup_top bup_checker #(.PROBE_CYC(PROBE_CYC), .INVITE_CYC(INVITE_CYC))
	u_bup_checker (.clk, .rst_b, .probe_found, .spi_mosi_o, .spi_mosi_oe,
	.spi_clk_o, .spi_clk_oe, .spi_chip_select_zero_o,
	.spi_chip_select_zero_oe, .two_wire_clock_line_oe,
	.external_chip_select_zero_b, .external_bus_width8, .usb_clock_pll_en,
	.usb_port_en, .usb_phase, .sram_we, .sram_addr, .periph_reset,
	.irq_disable, .jump_fetch, .remap, .jump_exec, .cpu_addr, .sel_sram,
	.sel_rom);

// [sim/bup_host.sv]
// host terminal model on the debug serial link
`timescale 1ns/1ps
module bup_host (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	// host stays silent, line idles at mark
	assign rxd = 1'b1;
	// receive one 8n1 character, lsb first, bounded wait for start
	task automatic get_byte(output logic [7:0] b, output logic ok);
		int n;
		b = 8'h00;
		n = 0;
		while (txd !== 1'b0 && n < 40000)
		begin
			@(posedge clk);
			n++;
		end
		repeat (bup_pkg::BAUD_DIV / 2) @(posedge clk);
		ok = (txd === 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			repeat (bup_pkg::BAUD_DIV) @(posedge clk);
			b[i] = txd;
		end
		repeat (bup_pkg::BAUD_DIV) @(posedge clk);
		ok = ok && (txd === 1'b1);
	endtask : get_byte
endmodule : bup_host

// [sim/boot_upload_sequencer_tb.sv]
// testbench: probe sequence, serial invite, usb upload, remap and jump
`timescale 1ns/1ps
module boot_upload_sequencer_tb;
	// stimulus
	logic clk, rst_b, boot_start, probe_valid, twd_i, lock, usb_enumerated;
	logic usb_upgrade_req, usb_byte_valid, usb_manifest;
	logic [7:0] usb_byte;
	logic [31:0] cpu_addr;
	// observed outputs
	logic probe_found, spi_mosi_oe, two_wire_clock_line_oe, twi_data_level_q;
	logic external_chip_select_zero_b, external_bus_width8, txd, rxd;
	logic usb_port_en, sram_we, periph_reset, irq_disable, remap, jump_exec;
	logic sel_sram, sel_rom;
	logic [1:0] usb_phase;
	logic [31:0] sram_addr;
	logic [7:0] sram_wdata;
	int n_errors = 0;
	int n_checks = 0;
	// design with short probe and invite counts
	bup_top #(.PROBE_CYC(200), .INVITE_CYC(20000)) u_bup_top (.clk, .rst_b,
		.boot_start, .probe_valid, .probe_found, .spi_mosi_o(), .spi_mosi_oe,
		.spi_clk_o(), .spi_clk_oe(), .spi_chip_select_zero_o(),
		.spi_chip_select_zero_oe(), .two_wire_clock_line_o(),
		.two_wire_clock_line_oe, .two_wire_data_line_i(twd_i),
		.two_wire_data_line_o(), .two_wire_data_line_oe(), .twi_data_level_q,
		.external_chip_select_zero_b, .external_bus_width8,
		.debug_serial_port_rxd(rxd), .debug_serial_port_txd(txd),
		.usb_clock_pll_en(), .usb_clock_pll_lock(lock), .usb_port_en,
		.usb_enumerated, .usb_upgrade_req, .usb_byte_valid, .usb_byte,
		.usb_manifest, .usb_phase, .sram_we, .sram_addr, .sram_wdata,
		.upload_overflow(), .periph_reset, .irq_disable, .jump_fetch(), .remap,
		.jump_exec, .cpu_addr, .sel_sram, .sel_rom);
	// host terminal on the serial link
	bup_host u_bup_host (.clk, .txd, .rxd);
	// 100 mhz clock
	always #5 clk = ~clk;
	// compare one value, count and report
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// let n edges pass, then settle past the edge
	task automatic wt(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt
	// probe order and pins driven in each probe
	task automatic t_probe();
		@(posedge clk);
		boot_start <= 1'b1;
		lock <= 1'b1;
		twd_i <= 1'b0;
		@(posedge clk);
		boot_start <= 1'b0;
		wt(50);
		chk("spi oe", spi_mosi_oe, 1'b1);
		chk("rom at zero", sel_rom, 1'b1);
		wt(100);
		chk("twi clk oe", two_wire_clock_line_oe, 1'b1);
		chk("spi off", spi_mosi_oe, 1'b0);
		wt(58);
		chk("cs zero", external_chip_select_zero_b, 1'b0);
		chk("width8", external_bus_width8, 1'b1);
		chk("twi data in", twi_data_level_q, 1'b0);
	endtask : t_probe
	// invite character sent and repeated
	task automatic t_invite();
		logic [7:0] b;
		logic ok;
		repeat (2)
		begin
			u_bup_host.get_byte(b, ok);
			chk("invite", b, 8'h43);
			chk("framing", ok, 1'b1);
		end
	endtask : t_invite
	// usb upgrade phases, image bytes into sram, cleanup and jump
	task automatic t_usb();
		int n;
		chk("usb port", usb_port_en, 1'b1);
		chk("phase", usb_phase, 2'h0);
		@(posedge clk);
		usb_enumerated <= 1'b1;
		wt(4);
		chk("phase", usb_phase, 2'h1);
		@(posedge clk);
		usb_upgrade_req <= 1'b1;
		wt(4);
		chk("phase", usb_phase, 2'h2);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			usb_byte_valid <= 1'b1;
			usb_byte <= 8'h5a ^ 8'(i);
			@(posedge clk);
			usb_byte_valid <= 1'b0;
			n = 0;
			#1;
			while (sram_we !== 1'b1 && n < 3)
			begin
				wt(1);
				n++;
			end
			chk("we", sram_we, 1'b1);
			chk("addr", sram_addr, 32'(bup_pkg::SRAM_BASE + i));
			chk("data", sram_wdata, 8'h5a ^ 8'(i));
		end
		@(posedge clk);
		usb_manifest <= 1'b1;
		n = 0;
		wt(1);
		while (periph_reset !== 1'b1 && n < 10)
		begin
			wt(1);
			n++;
		end
		n = 0;
		while (periph_reset === 1'b1 && n < 40)
		begin
			wt(1);
			n++;
		end
		chk("reset len", n, 16);
		n = 0;
		while (jump_exec !== 1'b1 && n < 10)
		begin
			wt(1);
			n++;
		end
		chk("jump", jump_exec, 1'b1);
		chk("remap", remap, 1'b1);
		chk("irq off", irq_disable, 1'b1);
		chk("phase", usb_phase, 2'h3);
		@(posedge clk);
		cpu_addr <= 32'h0000_0000;
		#1;
		chk("sram at zero", sel_sram, 1'b1);
		@(posedge clk);
		cpu_addr <= bup_pkg::ROM_BASE;
		#1;
		chk("rom high", sel_rom, 1'b1);
	endtask : t_usb
	// verdict and end of run
	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	// main sequence
	initial
	begin
		{clk, rst_b, boot_start, probe_valid, twd_i, lock} = 6'h00;
		{usb_enumerated, usb_upgrade_req, usb_byte_valid, usb_manifest} = 4'h0;
		usb_byte = 8'h00;
		cpu_addr = 32'h0000_0000;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_probe();
		t_invite();
		t_usb();
		summarize();
	end
	// hang guard, nearly three times the expected run
	initial
	begin
		repeat (80000) @(posedge clk);
		n_errors++;
		summarize();
	end
endmodule : boot_upload_sequencer_tb
